// ---- hdl/swto_pkg.sv ----
// Purpose: shared constants, types and helpers of the software trace
//          output unit
// Assumes: 32-bit classic Wishbone slave, one 25 MHz clock
// Notes:   Overview of operation below lists the behaviour kept by the unit
//
// Overview of operation
// - pc checkpoint emits current program counter
// - tag emits 10-bit immediate, optional pc
// - register push emits registers ascending, optional pc
// - items staged internally, then shifted to probe
// - no probe attached means no output
// - close items absorbed, lost once seven stages hold items
// - eight stages, overflow marker in eighth
// - pc with its value shares one stage
// - probe attach zero-fills all ram areas
// - with probe attached, interface select reads 01b, writes blocked
// - with probe attached, timer select reads 0, writes blocked
package swto_pkg;
   localparam int CLK_NS = 40;
   // port transfer times at the probe rate; serial timing here is slower
   localparam int PC_ITEM_NS = 1727;
   localparam int TAG_ITEM_NS = 576;
   localparam int PC_ITEM_CYC = (PC_ITEM_NS / CLK_NS > 0) ?
      PC_ITEM_NS / CLK_NS : 1;
   localparam int TAG_ITEM_CYC = (TAG_ITEM_NS / CLK_NS > 0) ?
      TAG_ITEM_NS / CLK_NS : 1;
   localparam int BUF_STAGES = 8;
   localparam int BIT_CYC = 2;
   localparam int RAM_AW = 10;

   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STAT = 8'h04;
   localparam logic [7:0] ADR_MASK = 8'h08;
   localparam logic [7:0] ADR_OPT0 = 8'h0C;
   localparam logic [7:0] ADR_OPT2 = 8'h10;
   localparam logic [7:0] ADR_INFO = 8'h14;
   localparam logic [7:0] ADR_LOST = 8'h18;

   localparam int CTRL_EN_BIT = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [31:0] OPT0_RST = 32'h0000_0002;
   localparam logic [31:0] OPT2_RST = 32'h6000_0000;
   localparam int SEL_HI_BIT = 30;
   localparam int SEL_LO_BIT = 29;
   localparam int TMR_SEL_BIT = 1;
   localparam logic [1:0] SEL_FOUR_PIN = 2'h1;

   localparam int ST_SENT = 0;
   localparam int ST_OVF = 1;
   localparam int ST_ATT = 2;
   localparam int ST_RAM = 3;
   localparam int ST_W = 4;

   localparam int PC_W = 32;
   localparam int IMM_W = 10;
   localparam int PAY_W = 37;
   localparam int HDR_W = 3;

   typedef enum logic [1:0] {K_PC, K_TAG, K_REG, K_OVF} swto_kind_t;
   typedef enum logic [1:0] {OP_PC, OP_TAG, OP_PUSH} swto_op_t;

   typedef struct packed {
      swto_kind_t kind;
      logic has_pc;
      logic [PC_W-1:0] pc;
      logic [PAY_W-1:0] payload;
   } swto_item_t;

   localparam int ITEM_W = $bits(swto_item_t);

   // number of bits that leave the port for one item
   function automatic logic [6:0] item_bits(input swto_item_t it);
      logic [6:0] n;
      case (it.kind)
         K_TAG: n = 7'h0A;
         K_REG: n = 7'h25;
         default: n = 7'h00;
      endcase
      return 7'(HDR_W) + (it.has_pc ? 7'h20 : 7'h00) + n;
   endfunction

   // header first, pc only when present, payload left-justified
   function automatic logic [ITEM_W-1:0] item_frame(input swto_item_t it);
      if (it.has_pc)
         return it;
      return {it.kind, it.has_pc, it.payload, 32'h0000_0000};
   endfunction

   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction
endpackage

// ---- hdl/swto_item_if.sv ----
// Purpose: one trace item moving between stages
// Assumes: valid/ready, transfer when both high at a rising edge
// Notes:   used between intake, buffer and serializer
`timescale 1ns/100ps
interface swto_item_if;
   logic valid;
   logic ready;
   swto_pkg::swto_item_t item;
   modport src (output valid, output item, input ready);
   modport dst (input valid, input item, output ready);
endinterface

// ---- hdl/swto_buf.sv ----
// Purpose: eight-stage internal trace buffer with overflow marker
// Assumes: producer cannot be stalled; input ready is always high
// Notes:   a full buffer drops items and reports each loss
`timescale 1ns/100ps
module swto_buf #(
   parameter int DEPTH = swto_pkg::BUF_STAGES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   swto_item_if.dst in_if,
   swto_item_if.src out_if,
   output logic [$clog2(DEPTH):0] level_o,
   output logic lost_o
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      swto_pkg::swto_item_t [DEPTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic lost;
   } swto_buf_state_t;
   swto_buf_state_t state_r, state_nxt;
   logic pop;
   logic push;

   always_comb begin
      state_nxt = state_r;
      state_nxt.lost = 1'b0;
      pop = out_if.ready && state_r.cnt != '0;
      push = 1'b0;
      if (pop)
         state_nxt.rd = state_r.rd + 1'b1;
      if (in_if.valid) begin
         if (state_r.cnt < (AW+1)'(DEPTH-1)) begin
            state_nxt.mem[state_r.wr] = in_if.item;
            push = 1'b1;
         end else if (state_r.cnt == (AW+1)'(DEPTH-1)) begin
            state_nxt.mem[state_r.wr] = '{kind: swto_pkg::K_OVF,
               has_pc: 1'b0, pc: '0, payload: '0};
            push = 1'b1;
            state_nxt.lost = 1'b1;
         end else begin
            state_nxt.lost = 1'b1;
         end
      end
      if (push)
         state_nxt.wr = state_r.wr + 1'b1;
      state_nxt.cnt = state_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         state_r <= '0;
      else
         state_r <= state_nxt;
   end

   assign in_if.ready = 1'b1;
   assign out_if.valid = state_r.cnt != '0;
   assign out_if.item = state_r.mem[state_r.rd];
   assign level_o = state_r.cnt;
   assign lost_o = state_r.lost;

   chk_stage_keeps_item: assert property (
      @(posedge clk_i) disable iff (rst_i)
      in_if.valid && state_r.cnt < (AW+1)'(DEPTH-1) |=>
      state_r.mem[$past(state_r.wr)] == $past(in_if.item))
      else $error("accepted item not stored");
   chk_marker_eighth: assert property (
      @(posedge clk_i) disable iff (rst_i)
      in_if.valid && state_r.cnt == (AW+1)'(DEPTH-1) |=>
      state_r.mem[$past(state_r.wr)].kind == swto_pkg::K_OVF && lost_o)
      else $error("overflow marker missing in last stage");
   cov_buffer_full: cover property (@(posedge clk_i) disable iff (rst_i)
      state_r.cnt == (AW+1)'(DEPTH));
endmodule // swto_buf

// ---- hdl/swto_ser.sv ----
// Purpose: shifts trace items out on the four-pin debug serial port
// Assumes: probe samples data on the rising edge of the port clock
// Notes:   port clock idles low; sync is high for the whole frame
`timescale 1ns/100ps
module swto_ser #(
   parameter int BIT_CYC = swto_pkg::BIT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   swto_item_if.dst in_if,
   output logic dsp_clk_o,
   output logic dsp_sync_o,
   output logic dsp_dout_o,
   output logic sent_o
);
   localparam int DW = $clog2(BIT_CYC);
   typedef enum logic [0:0] {SR_IDLE, SR_SHIFT} swto_ser_st_t;
   typedef struct packed {
      swto_ser_st_t st;
      logic [swto_pkg::ITEM_W-1:0] sh;
      logic [6:0] left;
      logic [DW-1:0] div;
      logic clk;
      logic sync;
      logic dout;
      logic sent;
   } swto_ser_state_t;
   swto_ser_state_t state_r, state_nxt;

   always_comb begin
      state_nxt = state_r;
      state_nxt.sent = 1'b0;
      case (state_r.st)
         SR_IDLE: begin
            if (in_if.valid) begin
               state_nxt.st = SR_SHIFT;
               state_nxt.sh = swto_pkg::item_frame(in_if.item);
               state_nxt.left = swto_pkg::item_bits(in_if.item);
               state_nxt.div = '0;
               state_nxt.sync = 1'b1;
               state_nxt.dout = in_if.item.kind[1];
            end
         end
         SR_SHIFT: begin
            state_nxt.div = state_r.div + 1'b1;
            if (state_r.div == DW'(BIT_CYC/2 - 1))
               state_nxt.clk = 1'b1;
            if (state_r.div == DW'(BIT_CYC-1)) begin
               state_nxt.div = '0;
               state_nxt.clk = 1'b0;
               state_nxt.sh = state_r.sh << 1;
               state_nxt.left = state_r.left - 7'h01;
               state_nxt.dout = state_r.sh[swto_pkg::ITEM_W-2];
               if (state_r.left == 7'h01) begin
                  state_nxt.st = SR_IDLE;
                  state_nxt.sync = 1'b0;
                  state_nxt.dout = 1'b0;
                  state_nxt.sent = 1'b1;
               end
            end
         end
         default: state_nxt = '0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         state_r <= '0;
      else
         state_r <= state_nxt;
   end

   assign in_if.ready = state_r.st == SR_IDLE;
   assign dsp_clk_o = state_r.clk;
   assign dsp_sync_o = state_r.sync;
   assign dsp_dout_o = state_r.dout;
   assign sent_o = state_r.sent;

   chk_frame_kind_first: assert property (@(posedge clk_i)
      disable iff (rst_i)
      in_if.valid && in_if.ready |=> dsp_sync_o &&
      dsp_dout_o == $past(in_if.item.kind[1]))
      else $error("frame does not open with its kind");
   cov_frame_sent: cover property (@(posedge clk_i) disable iff (rst_i)
      sent_o);
endmodule // swto_ser

// ---- hdl/swto_top.sv ----
// Purpose: software trace output unit: trace instruction intake,
//          staging, serial output, debug-fixed option bits, ram clear
// Assumes: register file read is combinational on gpr_idx_o
// Notes:   registers on classic Wishbone, ack one cycle after request
`timescale 1ns/100ps
module swto_top #(
   parameter int RAM_AW = swto_pkg::RAM_AW,
   parameter int DEPTH = swto_pkg::BUF_STAGES,
   parameter int BIT_CYC = swto_pkg::BIT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   input wire logic probe_attached_i,
   input wire logic ti_valid_i,
   input wire logic [1:0] ti_op_i,
   input wire logic ti_with_pc_i,
   input wire logic [9:0] ti_imm_i,
   input wire logic [4:0] ti_reg_lo_i,
   input wire logic [4:0] ti_reg_hi_i,
   input wire logic [31:0] ti_pc_i,
   output logic ti_ready_o,
   output logic [4:0] gpr_idx_o,
   input wire logic [31:0] gpr_val_i,
   output logic dsp_clk_o,
   output logic dsp_sync_o,
   output logic dsp_dout_o,
   output logic ram_zero_we_o,
   output logic [RAM_AW-1:0] ram_zero_addr_o,
   output logic [31:0] opt_word_zero_o,
   output logic [31:0] opt_word_two_o
);
   localparam int LW = $clog2(DEPTH) + 1;
   typedef enum logic [0:0] {S_IDLE, S_REGS} swto_st_t;
   typedef struct packed {
      swto_st_t st;
      logic rdy;
      logic [4:0] cur;
      logic [4:0] hi;
      logic first_pc;
      logic [31:0] pc;
      logic pv;
      swto_pkg::swto_item_t pitem;
      logic [4:0] gidx;
      logic ack;
      logic [31:0] rdat;
      logic [31:0] ctrl;
      logic [swto_pkg::ST_W-1:0] stat;
      logic [swto_pkg::ST_W-1:0] mask;
      logic [31:0] opt0;
      logic [31:0] opt2;
      logic [31:0] opt0_o;
      logic [31:0] opt2_o;
      logic [15:0] lost;
      logic att_d;
      logic sweep;
      logic [RAM_AW-1:0] raddr;
      logic irq;
   } swto_state_t;
   swto_state_t state_r, state_nxt;

   swto_item_if push_if ();
   swto_item_if pop_if ();
   logic [LW-1:0] level;
   logic buf_lost;
   logic sent;
   logic live;
   logic take;
   logic req;
   logic [31:0] wm;
   logic [31:0] wval;
   logic [swto_pkg::ST_W-1:0] set;
   logic [swto_pkg::ST_W-1:0] clr;

   // staging and serial output sit behind the intake
   swto_buf #(.DEPTH(DEPTH)) u_buf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_if(push_if),
      .out_if(pop_if),
      .level_o(level),
      .lost_o(buf_lost)
   );

   swto_ser #(.BIT_CYC(BIT_CYC)) u_ser (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_if(pop_if),
      .dsp_clk_o(dsp_clk_o),
      .dsp_sync_o(dsp_sync_o),
      .dsp_dout_o(dsp_dout_o),
      .sent_o(sent)
   );

   assign push_if.valid = state_r.pv;
   assign push_if.item = state_r.pitem;

   always_comb begin
      state_nxt = state_r;
      state_nxt.pv = 1'b0;
      set = '0;
      clr = '0;
      wval = '0;
      // instructions are still retired without a probe, just not traced
      live = probe_attached_i && state_r.ctrl[swto_pkg::CTRL_EN_BIT];
      take = ti_valid_i && state_r.rdy;

      case (state_r.st)
         S_IDLE: begin
            if (take && live) begin
               case (swto_pkg::swto_op_t'(ti_op_i))
                  swto_pkg::OP_PC: begin
                     state_nxt.pv = 1'b1;
                     state_nxt.pitem = '{kind: swto_pkg::K_PC,
                        has_pc: 1'b1, pc: ti_pc_i, payload: '0};
                  end
                  swto_pkg::OP_TAG: begin
                     state_nxt.pv = 1'b1;
                     state_nxt.pitem = '{kind: swto_pkg::K_TAG,
                        has_pc: ti_with_pc_i,
                        pc: ti_with_pc_i ? ti_pc_i : 32'h0000_0000,
                        payload: {ti_imm_i, 27'h0000000}};
                  end
                  swto_pkg::OP_PUSH: begin
                     state_nxt.st = S_REGS;
                     state_nxt.rdy = 1'b0;
                     state_nxt.cur = ti_reg_lo_i;
                     state_nxt.hi = ti_reg_hi_i;
                     state_nxt.gidx = ti_reg_lo_i;
                     state_nxt.first_pc = ti_with_pc_i;
                     state_nxt.pc = ti_with_pc_i ? ti_pc_i : 32'h0000_0000;
                  end
                  default: state_nxt.pv = 1'b0;
               endcase
            end
         end
         S_REGS: begin
            // the pc rides with the first register only, one stage each
            state_nxt.pv = 1'b1;
            state_nxt.pitem = '{kind: swto_pkg::K_REG,
               has_pc: state_r.first_pc, pc: state_r.pc,
               payload: {state_r.cur, gpr_val_i}};
            state_nxt.first_pc = 1'b0;
            state_nxt.pc = 32'h0000_0000;
            if (state_r.cur >= state_r.hi) begin
               state_nxt.st = S_IDLE;
               state_nxt.rdy = 1'b1;
            end else begin
               state_nxt.cur = state_r.cur + 5'h01;
               state_nxt.gidx = state_r.cur + 5'h01;
            end
         end
         default: begin
            state_nxt.st = S_IDLE;
            state_nxt.rdy = 1'b1;
         end
      endcase

      // ram clear sweep on each probe attach
      state_nxt.att_d = probe_attached_i;
      if (probe_attached_i && !state_r.att_d) begin
         state_nxt.sweep = 1'b1;
         state_nxt.raddr = '0;
      end else if (state_r.sweep) begin
         if (state_r.raddr == {RAM_AW{1'b1}}) begin
            state_nxt.sweep = 1'b0;
            set[swto_pkg::ST_RAM] = 1'b1;
         end else begin
            state_nxt.raddr = state_r.raddr + 1'b1;
         end
      end

      if (buf_lost && state_r.lost != 16'hFFFF)
         state_nxt.lost = state_r.lost + 16'h0001;
      set[swto_pkg::ST_SENT] = sent;
      set[swto_pkg::ST_OVF] = buf_lost;
      set[swto_pkg::ST_ATT] = probe_attached_i != state_r.att_d;

      // wishbone slave
      req = wb_cyc_i && wb_stb_i && !state_r.ack;
      state_nxt.ack = req;
      wm = swto_pkg::lane_mask(wb_sel_i);
      if (req && wb_we_i) begin
         case (wb_adr_i)
            swto_pkg::ADR_CTRL:
               state_nxt.ctrl = (state_r.ctrl & ~wm) | (wb_dat_i & wm);
            swto_pkg::ADR_STAT:
               clr = wb_dat_i[swto_pkg::ST_W-1:0] &
                  wm[swto_pkg::ST_W-1:0];
            swto_pkg::ADR_MASK:
               state_nxt.mask = (state_r.mask & ~wm[swto_pkg::ST_W-1:0]) |
                  (wb_dat_i[swto_pkg::ST_W-1:0] & wm[swto_pkg::ST_W-1:0]);
            swto_pkg::ADR_OPT0: begin
               state_nxt.opt0 = (state_r.opt0 & ~wm) | (wb_dat_i & wm);
               if (probe_attached_i)
                  state_nxt.opt0[swto_pkg::TMR_SEL_BIT] =
                     state_r.opt0[swto_pkg::TMR_SEL_BIT];
            end
            swto_pkg::ADR_OPT2: begin
               state_nxt.opt2 = (state_r.opt2 & ~wm) | (wb_dat_i & wm);
               if (probe_attached_i)
                  state_nxt.opt2[swto_pkg::SEL_HI_BIT:swto_pkg::SEL_LO_BIT] =
                     state_r.opt2[swto_pkg::SEL_HI_BIT:swto_pkg::SEL_LO_BIT];
            end
            default: clr = '0;
         endcase
      end
      case (wb_adr_i)
         swto_pkg::ADR_CTRL: wval = state_r.ctrl;
         swto_pkg::ADR_STAT: wval = 32'(state_r.stat);
         swto_pkg::ADR_MASK: wval = 32'(state_r.mask);
         swto_pkg::ADR_OPT0: wval = state_r.opt0_o;
         swto_pkg::ADR_OPT2: wval = state_r.opt2_o;
         swto_pkg::ADR_INFO: wval = 32'({state_r.sweep, probe_attached_i,
            state_r.st != S_IDLE || dsp_sync_o, 4'(level)});
         swto_pkg::ADR_LOST: wval = 32'(state_r.lost);
         default: wval = 32'h0000_0000;
      endcase
      if (req && !wb_we_i)
         state_nxt.rdat = wval;

      // set wins over a clear in the same cycle
      state_nxt.stat = (state_r.stat & ~clr) | set;
      state_nxt.irq = |(state_nxt.stat & state_nxt.mask);

      // the probe owns these bits while attached
      state_nxt.opt0_o = state_nxt.opt0;
      state_nxt.opt2_o = state_nxt.opt2;
      if (probe_attached_i) begin
         state_nxt.opt0_o[swto_pkg::TMR_SEL_BIT] = 1'b0;
         state_nxt.opt2_o[swto_pkg::SEL_HI_BIT:swto_pkg::SEL_LO_BIT] =
            swto_pkg::SEL_FOUR_PIN;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= '0;
         state_r.rdy <= 1'b1;
         state_r.ctrl <= swto_pkg::CTRL_RST;
         state_r.opt0 <= swto_pkg::OPT0_RST;
         state_r.opt2 <= swto_pkg::OPT2_RST;
         state_r.opt0_o <= swto_pkg::OPT0_RST;
         state_r.opt2_o <= swto_pkg::OPT2_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign wb_dat_o = state_r.rdat;
   assign wb_ack_o = state_r.ack;
   assign irq_o = state_r.irq;
   assign ti_ready_o = state_r.rdy;
   assign gpr_idx_o = state_r.gidx;
   assign ram_zero_we_o = state_r.sweep;
   assign ram_zero_addr_o = state_r.raddr;
   assign opt_word_zero_o = state_r.opt0_o;
   assign opt_word_two_o = state_r.opt2_o;

   chk_no_probe_silent: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ti_valid_i && ti_ready_o && !probe_attached_i |=> !push_if.valid)
      else $error("trace item made without probe");
   chk_pc_item_out: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ti_valid_i && ti_ready_o && probe_attached_i &&
      state_r.ctrl[swto_pkg::CTRL_EN_BIT] && ti_op_i == 2'h0 |=>
      push_if.valid && push_if.item.kind == swto_pkg::K_PC &&
      push_if.item.pc == $past(ti_pc_i))
      else $error("pc checkpoint item wrong");
   chk_tag_item_out: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ti_valid_i && ti_ready_o && live && ti_op_i == 2'h1 |=>
      push_if.item.kind == swto_pkg::K_TAG &&
      push_if.item.payload[36:27] == $past(ti_imm_i) &&
      push_if.item.has_pc == $past(ti_with_pc_i))
      else $error("tag item wrong");
   chk_regs_ascending: assert property (
      @(posedge clk_i) disable iff (rst_i)
      push_if.valid && push_if.item.kind == swto_pkg::K_REG ##1
      push_if.valid && push_if.item.kind == swto_pkg::K_REG &&
      !push_if.item.has_pc |->
      push_if.item.payload[36:32] == $past(push_if.item.payload[36:32])
      + 5'h01)
      else $error("register push not ascending");
   chk_ram_sweep_start: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $rose(probe_attached_i) |=> ram_zero_we_o &&
      ram_zero_addr_o == '0 ##1 ram_zero_we_o)
      else $error("ram clear did not start on attach");
   chk_sel_bits_fixed: assert property (
      @(posedge clk_i) disable iff (rst_i)
      probe_attached_i |=>
      opt_word_two_o[30:29] == 2'h1)
      else $error("interface select not four-pin");
   chk_timer_bit_fixed: assert property (
      @(posedge clk_i) disable iff (rst_i)
      probe_attached_i ##1 probe_attached_i |=>
      !opt_word_zero_o[1])
      else $error("timer select not zero");
   chk_irq_follows_stat: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r.stat & state_r.mask) != '0 |-> irq_o)
      else $error("irq low with unmasked status");
   cov_reg_push: cover property (@(posedge clk_i) disable iff (rst_i)
      state_r.st == S_REGS ##1 state_r.st == S_REGS);
   cov_ram_clear_done: cover property (@(posedge clk_i) disable iff (rst_i)
      $fell(ram_zero_we_o));
endmodule // swto_top

// ---- dv/swto_probe_model.sv ----
// Purpose: probe side of the debug serial port, collects whole frames
// Assumes: data is steady while the port clock rises
// Notes: sampled on the core clock, so no race with the port flops
`timescale 1ns/100ps
module swto_probe_model (
   input wire logic clk_i,
   input wire logic dsp_clk_i,
   input wire logic dsp_sync_i,
   input wire logic dsp_dout_i
);
   logic [71:0] sh_r = '0;
   int n_r = 0;
   logic clk_d = 1'b0;
   logic sync_d = 1'b0;
   logic [71:0] frm_q[$];
   int len_q[$];
   always @(posedge clk_i) begin
      clk_d <= dsp_clk_i;
      sync_d <= dsp_sync_i;
      if (dsp_sync_i && dsp_clk_i && !clk_d) begin
         sh_r <= {sh_r[70:0], dsp_dout_i};
         n_r <= n_r + 1;
      end
      // frame ends on sync fall; kind tag is its top bits
      if (sync_d && !dsp_sync_i) begin
         frm_q.push_back(sh_r);
         len_q.push_back(n_r);
         sh_r <= '0;
         n_r <= 0;
      end
   end
endmodule // swto_probe_model

// ---- dv/swto_top_bench.sv ----
// Purpose: self-checking bench of the software trace output unit
// Assumes: ack and ready are sampled at rising edges only
// Notes: small ram so the clear sweep stays short
`timescale 1ns/100ps
module swto_top_bench;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, att = 0;
   logic [7:0] adr = '0;
   logic [31:0] dat = '0, rd, pc = '0;
   logic [3:0] sel = 4'hF;
   logic tv = 0, twp = 0;
   logic [1:0] top = '0;
   logic [9:0] imm = '0;
   logic [4:0] lo = '0, hi = '0, gi;
   logic ack, irq, trdy, dclk, dsync, dout, zwe, dato;
   logic [3:0] zad;
   logic [31:0] o0, o2, wdo;
   int err_count = 0, n_tests = 0, cyc_n = 0, zn = 0, i;
   always #20 clk_i = ~clk_i;
   swto_top #(.RAM_AW(4)) swto_top_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
      .irq_o(irq), .probe_attached_i(att), .ti_valid_i(tv),
      .ti_op_i(top), .ti_with_pc_i(twp), .ti_imm_i(imm),
      .ti_reg_lo_i(lo), .ti_reg_hi_i(hi), .ti_pc_i(pc),
      .ti_ready_o(trdy), .gpr_idx_o(gi),
      .gpr_val_i({27'h0, gi} | 32'hC0DE_0000),
      .dsp_clk_o(dclk), .dsp_sync_o(dsync), .dsp_dout_o(dout),
      .ram_zero_we_o(zwe), .ram_zero_addr_o(zad),
      .opt_word_zero_o(o0), .opt_word_two_o(o2));
   swto_probe_model swto_probe_model_inst (.clk_i(clk_i),
      .dsp_clk_i(dclk), .dsp_sync_i(dsync), .dsp_dout_i(dout));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (zwe === 1'b1) zn <= zn + 1;
      if (zwe === 1'b1) chk(72'(zad), 72'(zn[3:0]));
      if (cyc_n == 20000) begin
         err_count++;
         finish_test();
      end
   end
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("Error at %0t: got %h exp %h", $time, got, exp);
         err_count++;
      end
   endtask
   // wishbone classic cycle: held until ack is seen at a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = wdo;
      {cyc, stb, we} <= 3'b000;
      @(posedge clk_i);
   endtask
   // software side never issues the debug trap; op 3 unused here
   task automatic ti(input logic [1:0] o, input logic p, input logic [9:0] m,
      input logic [4:0] l, input logic [4:0] h);
      @(posedge clk_i);
      {tv, top, twp, imm, lo, hi} <= {1'b1, o, p, m, l, h};
      do @(posedge clk_i); while (trdy !== 1'b1);
      tv <= 1'b0;
   endtask
   task automatic chkf(input int k, input logic [71:0] e, input int l);
      if (swto_probe_model_inst.frm_q.size() <= k) chk(72'h0, 72'h1);
      else begin
         chk(swto_probe_model_inst.frm_q[k], e);
         chk(72'(swto_probe_model_inst.len_q[k]), 72'(l));
      end
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      wb(0, 8'h00, 0); chk(rd, 32'h1);
      wb(0, 8'h08, 0); chk(rd, 32'h0);
      wb(0, 8'h40, 0); chk(rd, 32'h0);
      chk(o0, 32'h2);
      chk(o2, 32'h6000_0000);
      pc <= 32'h1234_5678;
      ti(0, 0, 0, 0, 0);
      repeat (150) @(posedge clk_i);
      chk(swto_probe_model_inst.frm_q.size(), 0);
      $display("test idle done");
      att <= 1;
      repeat (40) @(posedge clk_i);
      chk(zn, 16);
      wb(0, 8'h04, 0); chk(rd[3:2], 2'h3);
      wb(1, 8'h0C, 32'hFFFF_FFFF); wb(1, 8'h10, 0);
      wb(0, 8'h0C, 0); chk(rd, 32'hFFFF_FFFD);
      chk(o2, 32'h2000_0000);
      wb(1, 8'h04, 32'hF); wb(1, 8'h08, 32'h1);
      chk(irq, 1'b0);
      $display("test options done");
      ti(0, 0, 0, 0, 0);
      ti(1, 0, 10'h2A5, 0, 0);
      ti(2, 1, 0, 3, 4);
      repeat (500) @(posedge clk_i);
      chkf(0, {3'b001, 32'h1234_5678}, 35);
      chkf(1, {3'b010, 10'h2A5}, 13);
      chkf(2, {3'b101, 32'h1234_5678, 5'h3, 32'hC0DE_0003}, 72);
      chkf(3, {3'b100, 5'h4, 32'hC0DE_0004}, 40);
      chk(irq, 1'b1);
      wb(1, 8'h04, 32'h1); chk(irq, 1'b0);
      $display("test frames done");
      for (i = 0; i < 12; i++) ti(1, 0, 10'(i), 0, 0);
      repeat (800) @(posedge clk_i);
      chk(swto_probe_model_inst.frm_q.size(), 13);
      chkf(4, {3'b010, 10'h0}, 13);
      chkf(11, {3'b010, 10'h7}, 13);
      chkf(12, 3'b110, 3);
      wb(0, 8'h04, 0); chk(rd[1], 1'b1);
      wb(0, 8'h18, 0); chk(rd, 32'h4);
      wb(0, 8'h14, 0); chk(rd, 32'h20);
      $display("test overflow done");
      finish_test();
   end
endmodule // swto_top_bench
